//--- hdl/osc_sel_pkg.sv
package osc_sel_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [15:0] TRIM_ADDR   = 16'h0096;
  localparam logic [15:0] CLOCK_SOURCE_CONTROL_ADDR = 16'hffde;

  // trim register fields
  localparam int TRIM_LSB      = 0;
  localparam int TRIM_MSB      = 5;
  localparam int TRIM_CLKO_BIT = 6;
  localparam int TRIM_OVR_BIT  = 7;

  // clock control register fields
  localparam int CC_SEL_LSB   = 0;
  localparam int CC_SEL_MSB   = 2;
  localparam int CC_DBL_BIT   = 3;
  localparam int CC_WDX_BIT   = 4;
  localparam int CC_DONE_BIT  = 7;

  // user configuration bit holding the doubler reset value
  localparam int UCB_DBL_BIT  = 7;

  localparam logic [7:0] RDATA_NONE = 8'h00;

  // ********************************************************************
  // source select codes
  // ********************************************************************
  localparam logic [2:0] SRC_EXT   = 3'h7;
  localparam logic [2:0] SRC_WDOSC = 3'h4;
  localparam logic [2:0] SRC_RC    = 3'h3;
  localparam logic [2:0] SRC_XLO   = 3'h2;
  localparam logic [2:0] SRC_XMED  = 3'h1;
  localparam logic [2:0] SRC_XHI   = 3'h0;

  localparam int NUM_SRC = 8;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT_STABLE,
    SW_WAIT_EDGE
  } switch_state_e;

endpackage

//--- hdl/clk_div_if.sv
`timescale 1ns/1ps
interface clk_div_if #(parameter int DIV_W = 8);
  logic             osc_tick;
  logic [DIV_W-1:0] div_n;
  logic             cpu_tick;
  logic             periph_tick;

  modport ctl (output osc_tick, output div_n,
               input cpu_tick, input periph_tick);
  modport div (input osc_tick, input div_n,
               output cpu_tick, output periph_tick);
endinterface

//--- hdl/cpu_clk_div.sv
`timescale 1ns/1ps
module cpu_clk_div
  import osc_sel_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic clk_in,      // system clock
  input wire logic sys_rst_in,  // synchronous reset, active high
  clk_div_if.div   dv           // divider link
);

  // ********************************************************************
  // divide by twice n, n of zero passes through
  // ********************************************************************
  function automatic logic [DIV_W:0] last_count(logic [DIV_W-1:0] n);
    last_count = {n, 1'b0} - {{DIV_W{1'b0}}, 1'b1};
  endfunction

  logic [DIV_W:0] cnt_r;
  logic           cpu_tick_r;
  logic           periph_ph_r;
  logic           periph_tick_r;

  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div_w
    $error("cpu_clk_div: bad DIV_W");
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_r      <= '0;
      cpu_tick_r <= 1'b0;
    end else begin
      cpu_tick_r <= 1'b0;
      if (dv.osc_tick) begin
        if (dv.div_n == '0) begin
          cpu_tick_r <= 1'b1;
          cnt_r      <= '0;
        end else if (cnt_r >= last_count(dv.div_n)) begin
          cpu_tick_r <= 1'b1;
          cnt_r      <= '0;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  // peripheral clock at half the cpu clock
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      periph_ph_r   <= 1'b0;
      periph_tick_r <= 1'b0;
    end else begin
      periph_tick_r <= cpu_tick_r && periph_ph_r;
      if (cpu_tick_r) periph_ph_r <= ~periph_ph_r;
    end
  end

  assign dv.cpu_tick    = cpu_tick_r;
  assign dv.periph_tick = periph_tick_r;

  // ********************************************************************
  // checks
  // ********************************************************************
  AST_DIV_BYPASS: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (dv.osc_tick && dv.div_n == '0) |=> dv.cpu_tick)
    else $error("undivided osc tick lost");

  AST_DIV_SPACING: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (dv.cpu_tick && dv.div_n != '0 && !dv.osc_tick) |=> !dv.cpu_tick)
    else $error("divided cpu ticks too close");

  AST_PERIPH_HALF: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    dv.periph_tick |-> $past(dv.cpu_tick) && $past(periph_ph_r))
    else $error("peripheral tick not on every second cpu tick");

endmodule

//--- hdl/osc_select_and_clock_switch.sv
`timescale 1ns/1ps
module osc_select_and_clock_switch
  import osc_sel_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic        clk_in,                 // 250 MHz system clock
  input  wire logic        sys_rst_in,             // sync reset, high
  input  wire logic [15:0] sfr_addr_in,            // register address
  input  wire logic        sfr_wr_in,              // write strobe
  input  wire logic        sfr_rd_in,              // read strobe
  input  wire logic [7:0]  sfr_wdata_in,           // write data
  output logic      [7:0]  sfr_rdata_out,          // read data
  input  wire logic [5:0]  factory_trim_in,        // calibration value
  input  wire logic [7:0]  user_config_a_in,       // first config byte
  input  wire logic [7:0]  user_config_b_in,       // second config byte
  input  wire logic [7:0]  src_clk_in,             // raw source clocks
  input  wire logic [7:0]  src_stable_in,          // source stable flags
  input  wire logic        rtc_uses_crystal_in,    // rtc on crystal
  input  wire logic [DIV_W-1:0] cpu_clk_divider_in, // divider n
  input  wire logic        low_power_clk_req_in,   // low power request
  output logic             low_power_clk_out,      // low power clock bit
  output logic      [5:0]  rc_trim_out,            // rc trim code
  output logic             rc_doubler_out,         // rc doubler applied
  output logic             wdt_crystal_sel_out,    // watchdog on crystal
  output logic      [2:0]  active_source_out,      // source in use
  output logic             switch_done_out,        // switch complete
  output logic             cpu_clk_tick_out,       // cpu clock tick
  output logic             periph_clk_tick_out,    // peripheral tick
  output logic             crystal_out_pin_o_out,  // half cpu clock out
  output logic             crystal_out_pin_oe_out  // pin drive enable
);

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic is_crystal(logic [2:0] s);
    is_crystal = (s == SRC_XLO) || (s == SRC_XMED) || (s == SRC_XHI);
  endfunction

  if (DIV_W != 8) begin : g_bad_div_w
    $error("osc_select_and_clock_switch: DIV_W must be 8");
  end

  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  logic [NUM_SRC-1:0] clk_s1_r;
  logic [NUM_SRC-1:0] clk_s2_r;
  logic [NUM_SRC-1:0] clk_s3_r;
  logic [NUM_SRC-1:0] stb_s1_r;
  logic [NUM_SRC-1:0] stb_s2_r;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      clk_s1_r <= '0;
      clk_s2_r <= '0;
      clk_s3_r <= '0;
      stb_s1_r <= '0;
      stb_s2_r <= '0;
    end else begin
      clk_s1_r <= src_clk_in;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      stb_s1_r <= src_stable_in;
      stb_s2_r <= stb_s1_r;
    end
  end

  logic [NUM_SRC-1:0] src_rise;
  assign src_rise = clk_s2_r & ~clk_s3_r;

  // ********************************************************************
  // registers
  // ********************************************************************
  logic [5:0]    trim_code_r;
  logic          clk_out_en_r;
  logic          rc_override_sel_r;
  logic [2:0]    source_select_r;
  logic          rc_doubler_r;
  logic          wdt_crystal_sel_r;
  logic          switch_done_r;
  logic [2:0]    active_src_r;
  logic          dbl_active_r;
  switch_state_e sw_state_r;
  logic [7:0]    rdata_r;
  logic          low_power_clk_r;

  logic wr_trim;
  logic wr_clock_source_control;
  logic start_sw;
  logic handover;

  assign wr_trim   = sfr_wr_in && (sfr_addr_in == TRIM_ADDR);
  // writes while a switch runs are dropped
  assign wr_clock_source_control = sfr_wr_in && (sfr_addr_in == CLOCK_SOURCE_CONTROL_ADDR)
                     && switch_done_r;
  assign start_sw  = wr_clock_source_control
    && ((sfr_wdata_in[CC_SEL_MSB:CC_SEL_LSB] != active_src_r)
        || (sfr_wdata_in[CC_DBL_BIT] != dbl_active_r));

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      trim_code_r       <= factory_trim_in;
      clk_out_en_r      <= 1'b0;
      rc_override_sel_r <= 1'b0;
    end else if (wr_trim) begin
      trim_code_r       <= sfr_wdata_in[TRIM_MSB:TRIM_LSB];
      clk_out_en_r      <= sfr_wdata_in[TRIM_CLKO_BIT];
      rc_override_sel_r <= sfr_wdata_in[TRIM_OVR_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      source_select_r   <= user_config_a_in[CC_SEL_MSB:CC_SEL_LSB];
      rc_doubler_r      <= user_config_b_in[UCB_DBL_BIT];
      wdt_crystal_sel_r <= 1'b0;
    end else if (wr_clock_source_control) begin
      source_select_r   <= sfr_wdata_in[CC_SEL_MSB:CC_SEL_LSB];
      rc_doubler_r      <= sfr_wdata_in[CC_DBL_BIT];
      wdt_crystal_sel_r <= sfr_wdata_in[CC_WDX_BIT];
    end
  end

  // ********************************************************************
  // source switch sequencer
  // ********************************************************************
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sw_state_r <= SW_IDLE;
    end else begin
      case (sw_state_r)
        SW_IDLE:        if (start_sw) sw_state_r <= SW_WAIT_STABLE;
        SW_WAIT_STABLE: if (stb_s2_r[source_select_r])
                          sw_state_r <= SW_WAIT_EDGE;
        SW_WAIT_EDGE:   if (handover) sw_state_r <= SW_IDLE;
        default:        sw_state_r <= SW_IDLE;
      endcase
    end
  end

  // hand over on a new source edge so no runt pulse reaches the divider
  assign handover = (sw_state_r == SW_WAIT_EDGE)
                    && src_rise[source_select_r];

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      active_src_r <= user_config_a_in[CC_SEL_MSB:CC_SEL_LSB];
      dbl_active_r <= user_config_b_in[UCB_DBL_BIT];
    end else if (handover) begin
      active_src_r <= source_select_r;
      dbl_active_r <= rc_doubler_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      switch_done_r <= 1'b1;
    end else if (start_sw) begin
      switch_done_r <= 1'b0;
    end else if (handover) begin
      switch_done_r <= 1'b1;
    end
  end

  // ********************************************************************
  // read port
  // ********************************************************************
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_r <= RDATA_NONE;
    end else if (sfr_rd_in) begin
      case (sfr_addr_in)
        TRIM_ADDR:   rdata_r <= {rc_override_sel_r, clk_out_en_r,
                                 trim_code_r};
        CLOCK_SOURCE_CONTROL_ADDR: rdata_r <= {switch_done_r, 2'h0,
                                 wdt_crystal_sel_r, rc_doubler_r,
                                 source_select_r};
        default:     rdata_r <= RDATA_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) low_power_clk_r <= 1'b0;
    else            low_power_clk_r <= low_power_clk_req_in;
  end

  // ********************************************************************
  // clock path
  // ********************************************************************
  logic [2:0] eff_src;
  logic       crystal_used;
  logic       half_clk_r;

  assign eff_src = rc_override_sel_r ? SRC_RC : active_src_r;
  assign crystal_used = is_crystal(eff_src)
    || ((sw_state_r != SW_IDLE) && is_crystal(source_select_r))
    || wdt_crystal_sel_r || rtc_uses_crystal_in;

  clk_div_if #(.DIV_W(DIV_W)) dvi ();

  assign dvi.osc_tick = src_rise[eff_src];
  assign dvi.div_n    = cpu_clk_divider_in;

  cpu_clk_div #(.DIV_W(DIV_W)) u_div (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .dv         (dvi.div)
  );

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !clk_out_en_r) half_clk_r <= 1'b0;
    else if (dvi.cpu_tick) half_clk_r <= ~half_clk_r;
  end

  assign sfr_rdata_out          = rdata_r;
  assign low_power_clk_out      = low_power_clk_r;
  assign rc_trim_out            = trim_code_r;
  assign rc_doubler_out         = dbl_active_r;
  assign wdt_crystal_sel_out    = wdt_crystal_sel_r;
  assign active_source_out      = eff_src;
  assign switch_done_out        = switch_done_r;
  assign cpu_clk_tick_out       = dvi.cpu_tick;
  assign periph_clk_tick_out    = dvi.periph_tick;
  assign crystal_out_pin_o_out  = half_clk_r;
  assign crystal_out_pin_oe_out = clk_out_en_r && !crystal_used;

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_HALF_CPU_CLK_OUT_OFF: assert property (
    (is_crystal(eff_src) || wdt_crystal_sel_out) |-> !crystal_out_pin_oe_out)
    else $error("clock out driven while crystal in use");

  AST_HALF_TOGGLE: assert property (
    (cpu_clk_tick_out && clk_out_en_r) |=>
      (crystal_out_pin_o_out != $past(crystal_out_pin_o_out)))
    else $error("clock out missed a cpu tick");

  AST_TRIM_RESET: assert property (
    $past(sys_rst_in) |-> (!clk_out_en_r && !rc_override_sel_r
                           && rc_trim_out == $past(factory_trim_in)))
    else $error("trim register reset wrong");

  AST_TRIM_WRITE: assert property (
    wr_trim |=> rc_trim_out == $past(sfr_wdata_in[TRIM_MSB:TRIM_LSB]))
    else $error("trim code not retuned");

  AST_OVERRIDE: assert property (
    (wr_trim && sfr_wdata_in[TRIM_OVR_BIT]) |=>
      active_source_out == SRC_RC)
    else $error("override did not select rc oscillator");

  AST_DBL_APPLY: assert property (
    handover |=> rc_doubler_out == $past(rc_doubler_r))
    else $error("doubler not applied at handover");

  AST_DONE_CLEAR: assert property (
    start_sw |=> !switch_done_out [*2])
    else $error("done flag not cleared by new switch");

  AST_LOCKED: assert property (
    (!switch_done_out && sfr_wr_in && sfr_addr_in == CLOCK_SOURCE_CONTROL_ADDR)
      |=> $stable(source_select_r))
    else $error("control changed during switch");

  AST_CFG_RESET: assert property (
    $past(sys_rst_in) |-> (switch_done_out && !wdt_crystal_sel_out
      && source_select_r == $past(user_config_a_in[CC_SEL_MSB:CC_SEL_LSB])))
    else $error("control reset not from user config");

  AST_LP_RESET: assert property (
    $past(sys_rst_in) |-> !low_power_clk_out)
    else $error("low power bit not cleared by reset");

  AST_HANDOVER: assert property (
    $rose(switch_done_out) |-> (active_src_r == source_select_r)
      && $past(stb_s2_r[source_select_r], 2))
    else $error("switch finished before source was stable");

  AST_RSVD_ZERO: assert property (
    (sfr_rd_in && sfr_addr_in == CLOCK_SOURCE_CONTROL_ADDR) |=> sfr_rdata_out[6:5] == 2'h0)
    else $error("reserved control bits read nonzero");

  COV_SWITCH: cover property (start_sw ##[1:200] $rose(switch_done_out));
  COV_HALF_CPU_CLK_OUT: cover property (crystal_out_pin_oe_out && cpu_clk_tick_out);
  COV_OVERRIDE: cover property (wr_trim && sfr_wdata_in[TRIM_OVR_BIT]);
  COV_LOCKED: cover property (!switch_done_out && sfr_wr_in);

endmodule

//--- bench/tb_osc_select_and_clock_switch.sv
`timescale 1ns/1ps
module tb_osc_select_and_clock_switch
  import osc_sel_pkg::*;
;
  localparam logic [5:0] FTRIM = 6'h2a;

  logic        clk_in;
  logic        sys_rst_in;
  logic [15:0] sfr_addr_in;
  logic        sfr_wr_in;
  logic        sfr_rd_in;
  logic [7:0]  sfr_wdata_in;
  logic [7:0]  sfr_rdata_out;
  logic [7:0]  src_clk_in;
  logic [7:0]  src_stable_in;
  logic        rtc_uses_crystal_in;
  logic [7:0]  cpu_clk_divider_in;
  logic        low_power_clk_req_in;
  logic        low_power_clk_out;
  logic [5:0]  rc_trim_out;
  logic        rc_doubler_out;
  logic        wdt_crystal_sel_out;
  logic [2:0]  active_source_out;
  logic        switch_done_out;
  logic        cpu_clk_tick_out;
  logic        periph_clk_tick_out;
  logic        pin_o;
  logic        pin_oe;
  logic [7:0]  src_cnt;
  int          failures = 0;
  int          checks = 0;

  osc_select_and_clock_switch #(.DIV_W(8)) dut_u (
    .clk_in                 (clk_in),
    .sys_rst_in             (sys_rst_in),
    .sfr_addr_in            (sfr_addr_in),
    .sfr_wr_in              (sfr_wr_in),
    .sfr_rd_in              (sfr_rd_in),
    .sfr_wdata_in           (sfr_wdata_in),
    .sfr_rdata_out          (sfr_rdata_out),
    .factory_trim_in        (FTRIM),
    .user_config_a_in       (8'hf9),
    .user_config_b_in       (8'h80),
    .src_clk_in             (src_clk_in),
    .src_stable_in          (src_stable_in),
    .rtc_uses_crystal_in    (rtc_uses_crystal_in),
    .cpu_clk_divider_in     (cpu_clk_divider_in),
    .low_power_clk_req_in   (low_power_clk_req_in),
    .low_power_clk_out      (low_power_clk_out),
    .rc_trim_out            (rc_trim_out),
    .rc_doubler_out         (rc_doubler_out),
    .wdt_crystal_sel_out    (wdt_crystal_sel_out),
    .active_source_out      (active_source_out),
    .switch_done_out        (switch_done_out),
    .cpu_clk_tick_out       (cpu_clk_tick_out),
    .periph_clk_tick_out    (periph_clk_tick_out),
    .crystal_out_pin_o_out  (pin_o),
    .crystal_out_pin_oe_out (pin_oe)
  );

  // ****************************************************************
  // clock and source oscillators
  // ****************************************************************
  initial clk_in = 1'b0;
  always #2 clk_in = ~clk_in;

  // every source rises once per 4 system cycles
  always @(negedge clk_in) begin
    src_cnt    <= src_cnt + 8'h01;
    src_clk_in <= {8{src_cnt[1]}};
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    sfr_addr_in  = a;
    sfr_wdata_in = d;
    sfr_wr_in    = 1'b1;
    @(negedge clk_in);
    sfr_wr_in    = 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_rd_in   = 1'b1;
    @(negedge clk_in);
    sfr_rd_in   = 1'b0;
    d           = sfr_rdata_out;
  endtask

  // waits for a cpu (sel 0) or peripheral (sel 1) tick, returns cycles
  task automatic next_tick(input bit sel, output int w);
    w = 0;
    do begin
      @(negedge clk_in);
      w++;
    end while ((sel ? periph_clk_tick_out : cpu_clk_tick_out) !== 1'b1
               && w < 600);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [7:0] d;
    reg_rd(TRIM_ADDR, d);
    check(d, {2'b00, FTRIM}, "trim reset");
    reg_rd(CLOCK_SOURCE_CONTROL_ADDR, d);
    check(d, 8'h89, "control reset");
    check({7'h0, low_power_clk_out}, 8'h00, "low power reset");
    check({5'h0, active_source_out}, 8'h01, "source reset");
    reg_rd(16'h1234, d);
    check(d, 8'h00, "unmapped read");
  endtask

  task automatic t_trim();
    logic [7:0] d;
    reg_wr(TRIM_ADDR, 8'h7f);
    check({2'b00, rc_trim_out}, 8'h3f, "trim code");
    check({7'h0, pin_oe}, 8'h00, "clock out on crystal source");
    reg_rd(TRIM_ADDR, d);
    check(d, 8'h7f, "trim readback");
    reg_wr(TRIM_ADDR, 8'hbf);
    check({5'h0, active_source_out}, 8'h03, "override to rc");
    reg_wr(TRIM_ADDR, {2'b01, FTRIM});
    check({5'h0, active_source_out}, 8'h01, "override off");
  endtask

  task automatic switch_to(input logic [2:0] s, input logic dbl);
    logic [2:0] old;
    logic [7:0] d;
    int         w;
    old           = active_source_out;
    src_stable_in = ~(8'h01 << s);
    reg_wr(CLOCK_SOURCE_CONTROL_ADDR, {4'h0, dbl, s});
    @(negedge clk_in);
    check({7'h0, switch_done_out}, 8'h00, "done clears");
    reg_rd(CLOCK_SOURCE_CONTROL_ADDR, d);
    check({7'h0, d[7]}, 8'h00, "done reads low");
    reg_wr(CLOCK_SOURCE_CONTROL_ADDR, {4'h0, ~dbl, ~s});
    check({5'h0, active_source_out}, {5'h0, old}, "old source kept");
    src_stable_in = 8'hff;
    w = 0;
    while (switch_done_out !== 1'b1 && w < 50) begin
      @(negedge clk_in);
      w++;
    end
    check({5'h0, active_source_out}, {5'h0, s}, "new source");
    check({7'h0, rc_doubler_out}, {7'h0, dbl}, "doubler");
    check({7'h0, pin_oe},
          {7'h0, s == SRC_EXT || s == SRC_WDOSC || s == SRC_RC},
          "clock out enable");
    reg_rd(CLOCK_SOURCE_CONTROL_ADDR, d);
    check(d, {4'h8, dbl, s}, "control after switch");
  endtask

  task automatic t_codes();
    logic [2:0] codes [6];
    codes = '{SRC_EXT, SRC_WDOSC, SRC_XLO, SRC_XMED, SRC_XHI, SRC_RC};
    for (int i = 0; i < 6; i++) begin
      switch_to(codes[i], i[0]);
    end
  endtask

  task automatic t_reserved();
    logic [7:0] d;
    reg_wr(CLOCK_SOURCE_CONTROL_ADDR, 8'h7b);
    check({7'h0, switch_done_out}, 8'h01, "no switch");
    check({7'h0, wdt_crystal_sel_out}, 8'h01, "watchdog crystal");
    check({7'h0, pin_oe}, 8'h00, "clock out on watchdog crystal");
    reg_rd(CLOCK_SOURCE_CONTROL_ADDR, d);
    check(d, 8'h9b, "reserved bits");
    reg_wr(CLOCK_SOURCE_CONTROL_ADDR, 8'h0b);
    check({7'h0, wdt_crystal_sel_out}, 8'h00, "watchdog off");
  endtask

  task automatic t_divider();
    int   w;
    logic p0;
    for (int n = 0; n < 3; n++) begin
      @(negedge clk_in);
      cpu_clk_divider_in = n[7:0];
      next_tick(1'b0, w);
      next_tick(1'b0, w);
      p0 = pin_o;
      next_tick(1'b0, w);
      check(w[7:0], (n == 0) ? 8'h04 : 8'(8 * n), "cpu period");
      check({7'h0, pin_o}, {7'h0, ~p0}, "pin toggles");
      next_tick(1'b1, w);
      next_tick(1'b1, w);
      check(w[7:0], (n == 0) ? 8'h08 : 8'(16 * n), "periph period");
    end
    @(negedge clk_in);
    rtc_uses_crystal_in = 1'b1;
    @(negedge clk_in);
    check({7'h0, pin_oe}, 8'h00, "rtc on crystal");
    rtc_uses_crystal_in = 1'b0;
  endtask

  task automatic t_lowpwr();
    @(negedge clk_in);
    low_power_clk_req_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check({7'h0, low_power_clk_out}, 8'h01, "low power set");
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check({7'h0, low_power_clk_out}, 8'h00, "low power reset");
    check({5'h0, active_source_out}, 8'h01, "second reset");
    sys_rst_in = 1'b0;
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    sys_rst_in = 1'b1;
    sfr_addr_in = 16'h0000;
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    sfr_wdata_in = 8'h00;
    src_cnt = 8'h00;
    src_clk_in = 8'h00;
    src_stable_in = 8'hff;
    rtc_uses_crystal_in = 1'b0;
    cpu_clk_divider_in = 8'h00;
    low_power_clk_req_in = 1'b0;
    repeat (4) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_trim();
    t_codes();
    t_reserved();
    t_divider();
    t_lowpwr();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    wrap_up();
  end
endmodule
